//--- pkg/dtp_params.svh
// Behaviour
// R1: demod single-pass: long counter ignores later carrier edges after capture, keeps counting.
// R2: short timeout in demod: long counter captures count, irq if enabled, no reload.
// R3: writing single-pass 0 then 1 re-arms one capture-and-reload on next selected edge.
// R4: long counter at zero wraps to FFFFh, sets timeout status, irq if enabled.
// R5: software uses ping-pong only in transmit, both counters single-pass, shared select set.
// R6: ping-pong starts when software enables either counter; that counter runs first.
// R7: short counter start: output takes initial level, loads high or low reload by level.
// R8: short terminal count: short disabled, long enabled with initial level, loads reload.
// R9: long terminal count in ping-pong: long stops, short enabled again, repeating.
// R10: terminal-count interrupt requested only when that counter's interrupt enable is set.
// R11: writing 00 to ping-pong select stops the alternation.
// R12: software disables counters and clears flags before enabling ping-pong.
// R13: software disables counters before switching between transmit and demodulation mode.
// R14: interrupt requests held pending until software or acknowledge clears them.
`ifndef DTP_PARAMS_SVH
`define DTP_PARAMS_SVH

`define DTP_OFF_SHORT_CTRL  8'h00
`define DTP_OFF_SHARED_CTRL 8'h04
`define DTP_OFF_LONG_CTRL   8'h08
`define DTP_OFF_SHORT_RH    8'h0C
`define DTP_OFF_SHORT_RL    8'h10
`define DTP_OFF_LONG_RH     8'h14
`define DTP_OFF_LONG_RL     8'h18
`define DTP_OFF_IRQ_STAT    8'h1C
`define DTP_OFF_IRQ_MASK    8'h20
`define DTP_OFF_COUNT       8'h24
`define DTP_OFF_CAPTURE     8'h28

// per-counter control bits
`define DTP_B_EN      7
`define DTP_B_ONESHOT 6
`define DTP_B_TIMEOUT 5
`define DTP_B_CAPIE   2
`define DTP_B_TCIE    1
// shared control bits
`define DTP_B_TXMODE  7
`define DTP_B_EDGE_HI 5
`define DTP_B_EDGE_LO 4
`define DTP_B_PP_HI   3
`define DTP_B_PP_LO   2
`define DTP_B_SINIT   1
`define DTP_B_LINIT   0
`define DTP_PP_SEL    2'h3

// interrupt status bits
`define DTP_IRQ_SHORT 0
`define DTP_IRQ_LTC   1
`define DTP_IRQ_LCAP  2
`define DTP_IRQ_W     3

`define DTP_RST_CTRL   8'h00
`define DTP_RST_RELOAD 8'h00
`define DTP_RST_MASK   3'h0

`endif

//--- pkg/dtp_pkg.sv
package dtp_pkg;
    typedef enum logic [1:0] {
        DTP_BUS_IDLE  = 2'b00,
        DTP_BUS_WRITE = 2'b01,
        DTP_BUS_RWAIT = 2'b10,
        DTP_BUS_RDONE = 2'b11
    } dtp_bus_e;
    typedef logic [7:0] dtp_byte_t;
endpackage

//--- design/dtp_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module dtp_edge_sync
    import dtp_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin_in,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin_in;
            sync <= meta;
            prev <= sync;
        end
    end

    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
endmodule // dtp_edge_sync
`default_nettype wire

//--- design/dtp_down_counter.sv
`timescale 1ns/10ps
`default_nettype none
module dtp_down_counter
    import dtp_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    input  wire logic             dec,
    output logic      [WIDTH-1:0] count,
    output logic                  zero
);
    // down count wraps from zero to all ones by itself
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (load) begin
            count <= load_val;
        end else if (dec) begin
            count <= count - WIDTH'(1);
        end
    end

    assign zero = (count == '0);
endmodule // dtp_down_counter
`default_nettype wire

//--- design/dtp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtp_params.svh"
module dtp_top
    import dtp_pkg::*;
#(
    parameter int SHORT_W = 8,
    parameter int LONG_W  = 16
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        carrier_in,
    input  wire logic        short_irq_ack,
    input  wire logic        long_irq_ack,
    output logic             short_counter_output,
    output logic             long_counter_output,
    output logic             short_counter_irq,
    output logic             long_counter_irq,
    output logic             irq
);
    dtp_bus_e           bus_state;
    dtp_bus_e           next_bus_state;
    logic [7:0]         addr_q;
    dtp_byte_t          short_counter_control;
    dtp_byte_t          shared_counter_control;
    dtp_byte_t          long_counter_control;
    dtp_byte_t          short_reload_high;
    dtp_byte_t          short_reload_low;
    dtp_byte_t          long_reload_high_byte;
    dtp_byte_t          long_reload_low_byte;
    logic [`DTP_IRQ_W-1:0] irq_stat;
    logic [`DTP_IRQ_W-1:0] irq_mask;
    logic [LONG_W-1:0]  capture;
    logic               long_armed;
    logic               timeout_flag;
    logic               short_run;
    logic               long_run;

    // bus decode
    logic               accept;
    logic               wr_en;
    logic [7:0]         wdat;
    logic               wr_sctl;
    logic               wr_shared;
    logic               wr_lctl;
    logic               wr_srh;
    logic               wr_srl;
    logic               wr_lrh;
    logic               wr_lrl;
    logic               wr_stat;
    logic               wr_mask;
    logic [31:0]        rd_word;

    assign accept    = hsel & htrans[1] & hready;
    assign wr_en     = (bus_state == DTP_BUS_WRITE);
    assign wdat      = hwdata[7:0];
    assign wr_sctl   = wr_en & (addr_q == `DTP_OFF_SHORT_CTRL);
    assign wr_shared = wr_en & (addr_q == `DTP_OFF_SHARED_CTRL);
    assign wr_lctl   = wr_en & (addr_q == `DTP_OFF_LONG_CTRL);
    assign wr_srh    = wr_en & (addr_q == `DTP_OFF_SHORT_RH);
    assign wr_srl    = wr_en & (addr_q == `DTP_OFF_SHORT_RL);
    assign wr_lrh    = wr_en & (addr_q == `DTP_OFF_LONG_RH);
    assign wr_lrl    = wr_en & (addr_q == `DTP_OFF_LONG_RL);
    assign wr_stat   = wr_en & (addr_q == `DTP_OFF_IRQ_STAT);
    assign wr_mask   = wr_en & (addr_q == `DTP_OFF_IRQ_MASK);

    // reads take one wait state so hrdata can come from a flop
    assign hreadyout = (bus_state != DTP_BUS_RWAIT);
    assign hresp     = 1'b0;

    always_comb begin
        next_bus_state = DTP_BUS_IDLE;
        case (bus_state)
            DTP_BUS_RWAIT: next_bus_state = DTP_BUS_RDONE;
            DTP_BUS_IDLE,
            DTP_BUS_WRITE,
            DTP_BUS_RDONE: begin
                if (accept) begin
                    next_bus_state = hwrite ? DTP_BUS_WRITE : DTP_BUS_RWAIT;
                end
            end
            default: next_bus_state = DTP_BUS_IDLE;
        endcase
    end

    // counter datapath
    logic [SHORT_W-1:0] short_count;
    logic [LONG_W-1:0]  long_count;
    logic               short_zero;
    logic               long_zero;
    logic               carrier_rise;
    logic               carrier_fall;
    logic               tx_mode;
    logic               pp_on;
    logic               short_tc;
    logic               long_tc;
    logic               short_stop;
    logic               long_stop;
    logic               pp_to_long;
    logic               pp_to_short;
    logic               next_short_en;
    logic               next_long_en;
    logic               short_start;
    logic               long_start;
    logic               next_short_out;
    logic               next_long_out;
    logic               short_load;
    logic [SHORT_W-1:0] short_load_val;
    logic               edge_hit;
    logic               edge_take;
    logic               demod_cap;
    logic               long_load;
    logic               arm_now;
    logic [`DTP_IRQ_W-1:0] irq_set;
    logic [`DTP_IRQ_W-1:0] irq_clr;

    assign tx_mode = shared_counter_control[`DTP_B_TXMODE];
    // a select of 00 leaves pp_on low and ends the alternation
    assign pp_on   = tx_mode &
                     (shared_counter_control[`DTP_B_PP_HI:`DTP_B_PP_LO] == `DTP_PP_SEL); // [R11]

    assign short_tc = short_run & short_zero;
    assign long_tc  = long_run & long_zero;

    assign short_stop  = short_tc & (short_counter_control[`DTP_B_ONESHOT] | pp_on);
    // in demod the long counter never stops at zero, it wraps
    assign long_stop   = tx_mode & long_tc & (long_counter_control[`DTP_B_ONESHOT] | pp_on);
    assign pp_to_long  = pp_on & short_tc; // [R8]
    assign pp_to_short = pp_on & long_tc;  // [R9]

    // enable bits: hardware hand-over and stop win over a software write; either enable starts a run
    assign next_short_en = pp_to_short ? 1'b1 :
                           short_stop  ? 1'b0 :
                           wr_sctl     ? wdat[`DTP_B_EN] :
                           short_counter_control[`DTP_B_EN]; // [R6] [R9]
    assign next_long_en  = pp_to_long  ? 1'b1 :
                           long_stop   ? 1'b0 :
                           wr_lctl     ? wdat[`DTP_B_EN] :
                           long_counter_control[`DTP_B_EN]; // [R6] [R8]

    assign short_start = next_short_en & ~short_run;
    assign long_start  = next_long_en & ~long_run;

    // a stopping counter keeps its level, the same as the long side
    assign next_short_out = short_start ? shared_counter_control[`DTP_B_SINIT] :
                            (short_tc & ~short_stop) ? ~short_counter_output :
                            short_counter_output; // [R7]
    assign short_load     = short_start | short_tc;
    assign short_load_val = next_short_out ? short_reload_high : short_reload_low; // [R7]

    assign next_long_out = long_start ? shared_counter_control[`DTP_B_LINIT] :
                           (tx_mode & long_tc & ~long_stop) ? ~long_counter_output :
                           long_counter_output; // [R8]

    assign edge_hit  = ~tx_mode & long_run &
                       ((shared_counter_control[`DTP_B_EDGE_LO] & carrier_rise) |
                        (shared_counter_control[`DTP_B_EDGE_HI] & carrier_fall));
    // single-pass takes only the armed edge, later edges are ignored
    assign edge_take = edge_hit & (~long_counter_control[`DTP_B_ONESHOT] | long_armed); // [R1] [R3]
    assign demod_cap = ~tx_mode & short_tc & long_run; // [R2]
    // no reload on short timeout, and none at zero in demod
    assign long_load = long_start | edge_take | (tx_mode & long_tc & ~long_stop); // [R2] [R4]
    assign arm_now   = wr_lctl & wdat[`DTP_B_ONESHOT] &
                       ~long_counter_control[`DTP_B_ONESHOT]; // [R3]

    assign irq_set[`DTP_IRQ_SHORT] = short_tc & short_counter_control[`DTP_B_TCIE]; // [R10]
    assign irq_set[`DTP_IRQ_LTC]   = long_tc & long_counter_control[`DTP_B_TCIE];   // [R4] [R10]
    assign irq_set[`DTP_IRQ_LCAP]  = demod_cap & long_counter_control[`DTP_B_CAPIE]; // [R2]
    assign irq_clr = (wr_stat ? wdat[`DTP_IRQ_W-1:0] : '0) |
                     {long_irq_ack, long_irq_ack, short_irq_ack};

    assign rd_word =
        (addr_q == `DTP_OFF_SHORT_CTRL)  ? {24'h000000, short_counter_control} :
        (addr_q == `DTP_OFF_SHARED_CTRL) ? {24'h000000, shared_counter_control} :
        (addr_q == `DTP_OFF_LONG_CTRL)   ? {24'h000000, long_counter_control[7:6], timeout_flag,
                                            long_counter_control[4:0]} :
        (addr_q == `DTP_OFF_SHORT_RH)    ? {24'h000000, short_reload_high} :
        (addr_q == `DTP_OFF_SHORT_RL)    ? {24'h000000, short_reload_low} :
        (addr_q == `DTP_OFF_LONG_RH)     ? {24'h000000, long_reload_high_byte} :
        (addr_q == `DTP_OFF_LONG_RL)     ? {24'h000000, long_reload_low_byte} :
        (addr_q == `DTP_OFF_IRQ_STAT)    ? {29'h00000000, irq_stat} :
        (addr_q == `DTP_OFF_IRQ_MASK)    ? {29'h00000000, irq_mask} :
        (addr_q == `DTP_OFF_COUNT)       ? {8'h00, short_count, long_count} :
        (addr_q == `DTP_OFF_CAPTURE)     ? {16'h0000, capture} :
        32'h00000000;

    dtp_edge_sync u_carrier (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  (carrier_in),
        .rise    (carrier_rise),
        .fall    (carrier_fall)
    );

    dtp_down_counter #(.WIDTH(SHORT_W)) u_short (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .load     (short_load),
        .load_val (short_load_val),
        .dec      (short_run),
        .count    (short_count),
        .zero     (short_zero)
    );

    dtp_down_counter #(.WIDTH(LONG_W)) u_long (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .load     (long_load), // [R4]
        .load_val ({long_reload_high_byte, long_reload_low_byte}),
        .dec      (long_run),
        .count    (long_count),
        .zero     (long_zero)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= DTP_BUS_IDLE;
            addr_q    <= 8'h00;
            hrdata    <= 32'h00000000;
        end else begin
            bus_state <= next_bus_state;
            if (accept) begin
                addr_q <= haddr[7:0];
            end
            if (bus_state == DTP_BUS_RWAIT) begin
                hrdata <= rd_word;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            short_counter_control  <= `DTP_RST_CTRL;
            shared_counter_control <= `DTP_RST_CTRL;
            long_counter_control   <= `DTP_RST_CTRL;
            short_reload_high      <= `DTP_RST_RELOAD;
            short_reload_low       <= `DTP_RST_RELOAD;
            long_reload_high_byte  <= `DTP_RST_RELOAD;
            long_reload_low_byte   <= `DTP_RST_RELOAD;
            irq_mask               <= `DTP_RST_MASK;
        end else begin
            if (wr_sctl) short_counter_control <= wdat;
            short_counter_control[`DTP_B_EN] <= next_short_en;
            if (wr_shared) shared_counter_control <= wdat;
            if (wr_lctl) long_counter_control <= wdat;
            long_counter_control[`DTP_B_EN] <= next_long_en;
            if (wr_srh) short_reload_high <= wdat;
            if (wr_srl) short_reload_low <= wdat;
            if (wr_lrh) long_reload_high_byte <= wdat;
            if (wr_lrl) long_reload_low_byte <= wdat;
            if (wr_mask) irq_mask <= wdat[`DTP_IRQ_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            short_run            <= 1'b0;
            long_run             <= 1'b0;
            short_counter_output <= 1'b0;
            long_counter_output  <= 1'b0;
            long_armed           <= 1'b0;
            capture              <= '0;
            timeout_flag         <= 1'b0;
            irq_stat             <= '0;
        end else begin
            short_run            <= next_short_en;
            long_run             <= next_long_en;
            short_counter_output <= next_short_out;
            long_counter_output  <= next_long_out;
            // re-arm wins over an edge landing in the same cycle
            long_armed <= arm_now | (long_armed & ~edge_hit); // [R1] [R3]
            if (edge_take | demod_cap) begin
                capture <= long_count; // [R2] [R3]
            end
            // set wins over a software clear in the same cycle
            timeout_flag <= (~tx_mode & long_tc) |
                            (timeout_flag & ~(wr_lctl & wdat[`DTP_B_TIMEOUT])); // [R4]
            irq_stat <= (irq_stat & ~irq_clr) | irq_set; // [R14]
        end
    end

    // pending levels toward the interrupt controller
    assign short_counter_irq = irq_stat[`DTP_IRQ_SHORT]; // [R14]
    assign long_counter_irq  = irq_stat[`DTP_IRQ_LTC] | irq_stat[`DTP_IRQ_LCAP]; // [R14]
    assign irq               = |(irq_stat & irq_mask);

    // only whole-word transfers are expected; size is not checked
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:8], htrans[0]};
endmodule // dtp_top
`default_nettype wire

//--- test/dtp_carrier_model.sv
`timescale 1ns/10ps
`default_nettype none
module dtp_carrier_model (
    input  wire logic       hclk,
    input  wire logic       burst_req,
    input  wire logic [7:0] burst_len,
    output logic            carrier_in
);
    // one burst gives one rising and one falling edge; line idles low with no carrier
    logic [7:0] left = 8'h00;
    assign carrier_in = (left != 8'h00);
    always @(posedge hclk) begin
        if (left != 8'h00)
            left <= left - 8'h01;
        else if (burst_req)
            left <= burst_len;
    end
endmodule // dtp_carrier_model
`default_nettype wire

//--- test/dtp_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtp_params.svh"
module dtp_top_assertions (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        short_irq_ack,
    input wire logic        short_counter_irq,
    input wire logic        long_counter_irq,
    input wire logic        irq
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // shadows of software-only bits; hardware never rewrites them
    logic       wr_ph;
    logic [7:0] wr_addr;
    logic       mask_short;
    logic       short_ie;
    logic       long_ie;
    wire        taken = hsel && htrans[1] && hready;
    wire        wr_stat = wr_ph && (wr_addr == `DTP_OFF_IRQ_STAT);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph      <= 1'b0;
            wr_addr    <= 8'h00;
            mask_short <= 1'b0;
            short_ie   <= 1'b0;
            long_ie    <= 1'b0;
        end else begin
            wr_ph   <= taken && hwrite;
            wr_addr <= haddr[7:0];
            if (wr_ph && wr_addr == `DTP_OFF_IRQ_MASK) mask_short <= hwdata[0];
            if (wr_ph && wr_addr == `DTP_OFF_SHORT_CTRL) short_ie <= hwdata[`DTP_B_TCIE];
            if (wr_ph && wr_addr == `DTP_OFF_LONG_CTRL) long_ie <= hwdata[`DTP_B_TCIE] | hwdata[`DTP_B_CAPIE];
        end
    end
    property p_read_wait;
        taken && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
    property p_resp_okay;
        hresp == 1'b0;
    endproperty
    a_resp_okay: assert property (p_resp_okay) else $error("response not okay");
    property p_irq_needs_source;
        !short_counter_irq && !long_counter_irq |-> !irq;
    endproperty
    a_irq_needs_source: assert property (p_irq_needs_source) else $error("irq without source");
    property p_irq_short_unmasked;
        short_counter_irq && mask_short |-> irq;
    endproperty
    a_irq_short_unmasked: assert property (p_irq_short_unmasked) else $error("unmasked irq low");
    property p_short_irq_held;
        short_counter_irq && !short_irq_ack && !wr_stat |=> short_counter_irq;
    endproperty
    a_short_irq_held: assert property (p_short_irq_held) else $error("short irq dropped");
    property p_short_ack_clears;
        $rose(short_counter_irq) && short_irq_ack |=> !short_counter_irq;
    endproperty
    a_short_ack_clears: assert property (p_short_ack_clears) else $error("ack did not clear");
    property p_short_irq_enabled;
        $rose(short_counter_irq) |-> $past(short_ie);
    endproperty
    a_short_irq_enabled: assert property (p_short_irq_enabled) else $error("short irq not enabled");
    property p_long_irq_enabled;
        $rose(long_counter_irq) |-> $past(long_ie);
    endproperty
    a_long_irq_enabled: assert property (p_long_irq_enabled) else $error("long irq not enabled");
    c_read: cover property (taken && !hwrite);
    c_short_tc: cover property ($rose(short_counter_irq));
    c_long_tc: cover property ($rose(long_counter_irq));
endmodule // dtp_top_assertions
bind dtp_top dtp_top_assertions u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .short_irq_ack, .short_counter_irq, .long_counter_irq, .irq
);
`default_nettype wire

//--- test/dtp_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtp_params.svh"
module dtp_top_tb_top;
    logic        hclk, hresetn, hsel, hwrite, short_irq_ack, long_irq_ack, burst_req;
    logic [31:0] haddr, hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  burst_len;
    wire logic   hreadyout, hresp, carrier_in, sco, lco, sirq, lirq, irq;
    wire logic [31:0] hrdata;
    int          n_errors, checks, cycles;
    dtp_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .carrier_in(carrier_in), .short_irq_ack(short_irq_ack),
        .long_irq_ack(long_irq_ack), .short_counter_output(sco), .long_counter_output(lco),
        .short_counter_irq(sirq), .long_counter_irq(lirq), .irq(irq));
    dtp_carrier_model u_carrier (.hclk(hclk), .burst_req(burst_req), .burst_len(burst_len),
        .carrier_in(carrier_in));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task automatic tally_and_finish;
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h00000000, r);
    endtask
    task automatic wait_hi(input logic lng, input int lim, output int n);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while ((lng ? lirq : sirq) !== 1'b1 && n < lim);
    endtask
    task automatic burst(input logic [7:0] len);
        burst_len <= len;
        burst_req <= 1'b1;
        @(posedge hclk);
        burst_req <= 1'b0;
        repeat (30) @(posedge hclk);
    endtask
    task automatic do_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    task automatic t_regs;
        logic [31:0] v;
        rd(`DTP_OFF_SHARED_CTRL, v);
        check("shared reset", v, 32'h0);
        wr(`DTP_OFF_SHORT_RH, 32'hA5);
        rd(`DTP_OFF_SHORT_RH, v);
        check("reload rw", v, 32'hA5);
        wr(8'h30, 32'hFF);
        rd(8'h30, v);
        check("unmapped", v, 32'h0);
    endtask
    task automatic t_wrap;
        logic [31:0] v;
        wr(`DTP_OFF_LONG_RL, 32'h03);
        wr(`DTP_OFF_LONG_CTRL, 32'h82);
        repeat (10) @(posedge hclk);
        rd(`DTP_OFF_LONG_CTRL, v);
        check("timeout flag", v & 32'h20, 32'h20);
        rd(`DTP_OFF_COUNT, v);
        check("long wrapped", v & 32'hFF00, 32'hFF00);
        check("long irq", {31'h0, lirq}, 32'h1);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(`DTP_OFF_IRQ_MASK, 32'h02);
        @(posedge hclk);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        long_irq_ack <= 1'b1;
        @(posedge hclk);
        long_irq_ack <= 1'b0;
        @(posedge hclk);
        check("long irq acked", {31'h0, lirq}, 32'h0);
    endtask
    task automatic t_capture;
        logic [31:0] c1, c2, v;
        do_reset();
        wr(`DTP_OFF_SHARED_CTRL, 32'h10);
        wr(`DTP_OFF_LONG_RH, 32'h80);
        wr(`DTP_OFF_LONG_CTRL, 32'hC4);
        burst(8'h14);
        rd(`DTP_OFF_CAPTURE, c1);
        check("first capture", c1 & 32'hFF00, 32'h7F00);
        burst(8'h03);
        rd(`DTP_OFF_CAPTURE, c2);
        check("edge ignored", c2, c1);
        wr(`DTP_OFF_LONG_CTRL, 32'h84);
        wr(`DTP_OFF_LONG_CTRL, 32'hC4);
        burst(8'h14);
        rd(`DTP_OFF_CAPTURE, c2);
        check("rearmed capture", {31'h0, c2 == c1}, 32'h0);
        repeat (100) @(posedge hclk);
        wr(`DTP_OFF_SHORT_RL, 32'h05);
        wr(`DTP_OFF_SHORT_CTRL, 32'hC0);
        repeat (20) @(posedge hclk);
        rd(`DTP_OFF_CAPTURE, c1);
        rd(`DTP_OFF_COUNT, v);
        check("timeout capture", {31'h0, c1 == c2}, 32'h0);
        check("no reload", {31'h0, v[15:0] < c1[15:0]}, 32'h1);
        check("short irq off", {31'h0, sirq}, 32'h0);
        rd(`DTP_OFF_IRQ_STAT, v);
        check("capture status", v, 32'h4);
        wr(`DTP_OFF_IRQ_STAT, 32'h04);
        @(posedge hclk);
        check("status cleared", {31'h0, lirq}, 32'h0);
    endtask
    task automatic t_pingpong;
        int n;
        do_reset();
        wr(`DTP_OFF_SHORT_RH, 32'h03);
        wr(`DTP_OFF_SHORT_RL, 32'h05);
        wr(`DTP_OFF_LONG_RL, 32'h04);
        wr(`DTP_OFF_SHARED_CTRL, 32'h8D);
        wr(`DTP_OFF_IRQ_MASK, 32'h03);
        wr(`DTP_OFF_LONG_CTRL, 32'h42);
        wr(`DTP_OFF_SHORT_CTRL, 32'hC2);
        wait_hi(1'b0, 20, n);
        check("short first", {31'h0, lirq}, 32'h0);
        check("irq on short tc", {31'h0, irq}, 32'h1);
        check("short level", {31'h0, sco}, 32'h0);
        // acks held high turn each terminal count into a one-cycle pulse
        short_irq_ack <= 1'b1;
        long_irq_ack <= 1'b1;
        wait_hi(1'b1, 20, n);
        check("long tc delay", n, 32'd5);
        check("long level", {31'h0, lco}, 32'h1);
        wait_hi(1'b0, 20, n);
        check("short tc delay", n, 32'd6);
        wr(`DTP_OFF_SHARED_CTRL, 32'h81);
        repeat (30) @(posedge hclk);
        wait_hi(1'b0, 40, n);
        check("stopped", n, 32'd40);
        short_irq_ack <= 1'b0;
        long_irq_ack <= 1'b0;
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        short_irq_ack = 1'b0;
        long_irq_ack = 1'b0;
        burst_req = 1'b0;
        burst_len = 8'h00;
        n_errors = 0;
        checks = 0;
        cycles = 0;
        do_reset();
        t_regs();
        t_wrap();
        t_capture();
        t_pingpong();
        tally_and_finish();
    end
endmodule // dtp_top_tb_top
`default_nettype wire
